/* src/eivu_pkg.sv */
/*
 * Package for the external interrupt and vector unit: vectors, polling
 * order, trigger encodings, timing counts and the carrier structs.
 * Assumes one machine cycle per clk_sys cycle.
 */
package eivu_pkg;

    // ------------------------------------------------------------
    // Sources in fixed polling order (index 0 polled first)
    // ------------------------------------------------------------
    localparam int NUM_SRC = 14;
    localparam int SRC_OVL = 0;
    localparam int SRC_EX0 = 1;
    localparam int SRC_TM0 = 2;
    localparam int SRC_EX1 = 3;
    localparam int SRC_TM1 = 4;
    localparam int SRC_SER = 5;
    localparam int SRC_TM2 = 6;
    localparam int SRC_ADC = 7;
    localparam int SRC_SPI = 8;
    localparam int SRC_EX2 = 9;
    localparam int SRC_EX3 = 10;
    localparam int SRC_EX4 = 11;
    localparam int SRC_PWM = 12;
    localparam int SRC_SCM = 13;

    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_EX0 = 16'h0003;
    localparam logic [15:0] VEC_TM0 = 16'h000B;
    localparam logic [15:0] VEC_EX1 = 16'h0013;
    localparam logic [15:0] VEC_TM1 = 16'h001B;
    localparam logic [15:0] VEC_SER = 16'h0023;
    localparam logic [15:0] VEC_TM2 = 16'h002B;
    localparam logic [15:0] VEC_ADC = 16'h0033;
    localparam logic [15:0] VEC_SPI = 16'h003B;
    localparam logic [15:0] VEC_EX2 = 16'h0043;
    localparam logic [15:0] VEC_EX3 = 16'h004B;
    localparam logic [15:0] VEC_EX4 = 16'h0053;
    localparam logic [15:0] VEC_PWM = 16'h0063;
    localparam logic [15:0] VEC_SCM = 16'h006B;
    localparam logic [15:0] VEC_OVL = 16'h007B;

    localparam logic [NUM_SRC*16-1:0] VEC_TABLE = {
        VEC_SCM, VEC_PWM, VEC_EX4, VEC_EX3, VEC_EX2, VEC_SPI, VEC_ADC,
        VEC_TM2, VEC_SER, VEC_TM1, VEC_EX1, VEC_TM0, VEC_EX0, VEC_OVL};

    // ------------------------------------------------------------
    // Trigger field encodings for sources two to four
    // ------------------------------------------------------------
    localparam logic [1:0] TRIG_LOW = 2'h0;
    localparam logic [1:0] TRIG_FALL = 2'h1;
    localparam logic [1:0] TRIG_RISE = 2'h2;
    localparam logic [1:0] TRIG_BOTH = 2'h3;

    // ------------------------------------------------------------
    // Timing, in machine cycles; source four pin count and level count
    // ------------------------------------------------------------
    localparam int CALL_CYCLES = 7;
    localparam int BLOCK_WAIT_CYCLES = 8;
    localparam int LONGEST_INSN_CYCLES = 20;
    localparam int POLL_DELAY_CYCLES = 2;
    localparam logic [3:0] CALL_CNT_LAST = 4'(CALL_CYCLES - 1);
    localparam logic [3:0] WAIT_CNT_LAST = 4'(BLOCK_WAIT_CYCLES - 1);
    localparam int EX4_PINS = 8;
    localparam int NUM_LVL = 4;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic last_cycle;
        logic is_reti;
        logic call_ack;
        logic reti_done;
        logic sleeping;
    } eivu_core_t;

    typedef struct packed {
        logic [15:0] vector;
        logic req;
        logic [1:0] level;
    } eivu_call_t;

endpackage

/* src/eivu_top.sv */
/*
 * External interrupt request logic and vectoring toward the CPU core.
 * Assumes pins are synchronous to clk_sys, one machine cycle per clock,
 * and that the core reports instruction end, return and call entry.
 */
// Function
// - Granted request calls vector next, else pends
// - Hardware call occupies exactly seven cycles
// - Raise request third cycle after recognition
// - Return-blocked vectoring adds eight cycle wait
// - Long multiply/divide completes before call
// - Latency between ten and thirty-seven cycles
// - Five external sources, source four eight pins
// - Trigger bit clear: low level requests
// - Trigger bit set: falling edge sets flag
// - Flags zero-three autoclear; source-four flags software
// - Level flag tracks pin, repeats after return
// - Enabled external interrupt wakes from sleep
// - Vectors for external zero, timers, reset
// - Serial, timer two, converter, SPI vectors
// - Sources two-four vectors, four double enable
// - PWM shared vector, clock monitor vector
// - Overload source first, no enable bit
// - Trigger field decodes low, fall, rise, both
// - Four levels, higher pre-empts, polling breaks ties
// - Call blocked by priority, mid-instruction, return
`timescale 1ns/1ps

module eivu_top
    import eivu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ext_irq_pin_zero,
    input wire logic ext_irq_pin_one,
    input wire logic ext_irq_pin_two,
    input wire logic ext_irq_pin_three,
    input wire logic [EX4_PINS-1:0] ext4_pins,
    input wire logic trig_sel_zero,
    input wire logic trig_sel_one,
    input wire logic [1:0] ext2_trig_field,
    input wire logic [1:0] ext3_trig_field,
    input wire logic [1:0] ext4_trig_field,
    input wire logic [EX4_PINS-1:0] ext4_flag_clear,
    input wire logic [NUM_SRC-1:0] src_enable,
    input wire logic global_enable,
    input wire logic ext4_channel_enable,
    input wire logic [NUM_SRC-1:0] periph_req,
    input wire logic pwm_irq_global_enable,
    input wire logic [2:0] pwm_channel_irq_enable,
    input wire logic [2:0] pwm_channel_irq_flag,
    input wire logic [NUM_SRC*2-1:0] src_prio,
    input wire eivu_core_t core_in,
    output eivu_call_t call_out,
    output logic [3:0] ext_req_flags,
    output logic [EX4_PINS-1:0] ext4_req_flag_x,
    output logic wake
);

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CALL} eivu_state_t;

    // ------------------------------------------------------------
    // Pin sampling and request flags
    // ------------------------------------------------------------
    logic [3:0] pin_prev_q;
    logic [3:0] pin_prev_d;
    logic [EX4_PINS-1:0] p4_prev_q;
    logic [EX4_PINS-1:0] p4_prev_d;
    logic [3:0] ext_flag_q;
    logic [3:0] ext_flag_d;
    logic [EX4_PINS-1:0] x4_flag_q;
    logic [EX4_PINS-1:0] x4_flag_d;
    logic [3:0] pins_now;
    logic [3:0] ack_clr;
    logic [NUM_SRC-1:0] ack_onehot;

    function automatic logic trig_hit(input logic [1:0] mode, input logic prev, input logic now);
        case (mode)
            TRIG_LOW: trig_hit = !now;
            TRIG_FALL: trig_hit = prev && !now;
            TRIG_RISE: trig_hit = !prev && now;
            TRIG_BOTH: trig_hit = prev != now;
            default: trig_hit = 1'b0;
        endcase
    endfunction

    assign pins_now = {ext_irq_pin_three, ext_irq_pin_two, ext_irq_pin_one, ext_irq_pin_zero};

    always_comb
    begin
        logic [1:0] mode [4];
        mode[0] = trig_sel_zero ? TRIG_FALL : TRIG_LOW;
        mode[1] = trig_sel_one ? TRIG_FALL : TRIG_LOW;
        mode[2] = ext2_trig_field;
        mode[3] = ext3_trig_field;
        pin_prev_d = pins_now;
        p4_prev_d = ext4_pins;
        ack_clr = {ack_onehot[SRC_EX3], ack_onehot[SRC_EX2], ack_onehot[SRC_EX1], ack_onehot[SRC_EX0]};
        for (int i = 0; i < 4; i++)
        begin
            if (mode[i] == TRIG_LOW)
                ext_flag_d[i] = !pins_now[i];
            else
                ext_flag_d[i] = trig_hit(mode[i], pin_prev_q[i], pins_now[i]) || (ext_flag_q[i] && !ack_clr[i]);
        end
        for (int j = 0; j < EX4_PINS; j++)
            x4_flag_d[j] = trig_hit(ext4_trig_field, p4_prev_q[j], ext4_pins[j])
                || (x4_flag_q[j] && !ext4_flag_clear[j]);
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_prev_q <= 4'hF;
            p4_prev_q <= 8'hFF;
            ext_flag_q <= 4'h0;
            x4_flag_q <= 8'h00;
        end
        else
        begin
            pin_prev_q <= pin_prev_d;
            p4_prev_q <= p4_prev_d;
            ext_flag_q <= ext_flag_d;
            x4_flag_q <= x4_flag_d;
        end
    end

    // ------------------------------------------------------------
    // Source gating, poll pipeline and selection
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] raw_req;
    logic [NUM_SRC-1:0] gated;
    logic [NUM_SRC-1:0] poll_q;
    logic [NUM_SRC-1:0] poll_d;
    logic [NUM_SRC-1:0] poll2_q;
    logic [NUM_SRC-1:0] poll2_d;
    logic [NUM_LVL-1:0] active_q;
    logic [NUM_LVL-1:0] active_d;
    logic sel_valid;
    logic [3:0] sel_idx;
    logic [1:0] sel_lvl;

    always_comb
    begin
        raw_req = periph_req;
        raw_req[SRC_EX0] = ext_flag_q[0];
        raw_req[SRC_EX1] = ext_flag_q[1];
        raw_req[SRC_EX2] = ext_flag_q[2];
        raw_req[SRC_EX3] = ext_flag_q[3];
        raw_req[SRC_EX4] = (|x4_flag_q) && ext4_channel_enable;
        raw_req[SRC_PWM] = pwm_irq_global_enable && |(pwm_channel_irq_flag & pwm_channel_irq_enable);
        gated = raw_req & src_enable & {NUM_SRC{global_enable}};
        gated[SRC_OVL] = raw_req[SRC_OVL];
        poll_d = gated;
        poll2_d = poll_q & gated;
    end

    // Highest level first, then lowest polling index
    always_comb
    begin
        sel_valid = 1'b0;
        sel_idx = 4'h0;
        sel_lvl = 2'h0;
        for (int l = 0; l < NUM_LVL; l++)
        begin
            for (int s = NUM_SRC - 1; s >= 0; s--)
            begin
                if (poll2_q[s] && src_prio[s*2 +: 2] == 2'(l))
                begin
                    sel_valid = 1'b1;
                    sel_idx = 4'(s);
                    sel_lvl = 2'(l);
                end
            end
        end
        if (poll2_q[SRC_OVL])
        begin
            sel_valid = 1'b1;
            sel_idx = 4'(SRC_OVL);
            sel_lvl = 2'(NUM_LVL - 1);
        end
        for (int m = 0; m < NUM_LVL; m++)
            if (active_q[m] && 2'(m) >= sel_lvl)
                sel_valid = 1'b0;
    end

    // ------------------------------------------------------------
    // Call sequencer toward the core
    // ------------------------------------------------------------
    eivu_state_t state_q;
    eivu_state_t state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    eivu_call_t call_q;
    eivu_call_t call_d;
    logic wake_q;
    logic wake_d;
    logic [3:0] call_idx_q;
    logic [3:0] call_idx_d;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        call_d = call_q;
        active_d = active_q;
        ack_onehot = '0;
        call_idx_d = call_idx_q;
        if (core_in.reti_done)
        begin
            for (int m = NUM_LVL - 1; m >= 0; m--)
                if (active_q[m] && active_d == active_q)
                    active_d[m] = 1'b0;
        end
        case (state_q)
            ST_IDLE:
            begin
                call_d.req = 1'b0;
                if (sel_valid)
                begin
                    if (core_in.last_cycle && !core_in.is_reti)
                    begin
                        state_d = ST_CALL;
                        cnt_d = 4'h0;
                        call_d.req = 1'b1;
                        call_d.vector = VEC_TABLE[sel_idx*16 +: 16];
                        call_d.level = sel_lvl;
                        call_idx_d = sel_idx;
                    end
                    else if (core_in.is_reti)
                    begin
                        state_d = ST_WAIT;
                        cnt_d = 4'h0;
                    end
                end
            end
            ST_WAIT:
            begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == WAIT_CNT_LAST)
                    state_d = ST_IDLE;
            end
            ST_CALL:
            begin
                if (cnt_q == 4'h0)
                begin
                    for (int s = 0; s < NUM_SRC; s++)
                        ack_onehot[s] = core_in.call_ack && call_idx_q == 4'(s);
                    if (core_in.call_ack)
                        active_d[call_q.level] = 1'b1;
                end
                call_d.req = 1'b1;
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == CALL_CNT_LAST)
                begin
                    state_d = ST_IDLE;
                    call_d.req = 1'b0;
                end
            end
            default:
                state_d = ST_IDLE;
        endcase
        wake_d = core_in.sleeping
            && |(gated & ~(NUM_SRC'(1) << SRC_OVL));
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            poll_q <= '0;
            poll2_q <= '0;
            active_q <= '0;
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            call_q <= '{vector: VEC_RESET, req: 1'b0, level: 2'h0};
            wake_q <= 1'b0;
            call_idx_q <= 4'h0;
        end
        else
        begin
            poll_q <= poll_d;
            poll2_q <= poll2_d;
            active_q <= active_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
            call_q <= call_d;
            wake_q <= wake_d;
            call_idx_q <= call_idx_d;
        end
    end

    assign call_out = call_q;
    assign ext_req_flags = ext_flag_q;
    assign ext4_req_flag_x = x4_flag_q;
    assign wake = wake_q;

endmodule

/* verif/eivu_properties.sv */
/* Port assertions for eivu_top.
   Assumes a bind to every eivu_top instance. */
`timescale 1ns/1ps
module eivu_properties
    import eivu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ext_irq_pin_zero,
    input wire logic trig_sel_zero,
    input wire logic ext_irq_pin_one,
    input wire logic trig_sel_one,
    input wire logic [EX4_PINS-1:0] ext4_flag_clear,
    input wire logic [NUM_SRC-1:0] src_enable,
    input wire logic global_enable,
    input wire eivu_core_t core_in,
    input wire eivu_call_t call_out,
    input wire logic [3:0] ext_req_flags,
    input wire logic [EX4_PINS-1:0] ext4_req_flag_x,
    input wire logic wake
);
    // ----
    // Checks
    // ----
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    a_call_seven: assert property ($rose(call_out.req) |-> call_out.req [*7] ##1 !call_out.req)
        else $error("call length wrong");
    a_edge_flag: assert property (trig_sel_zero && $fell(ext_irq_pin_zero) |-> ##[1:2] ext_req_flags[0])
        else $error("edge not flagged");
    a_level_set: assert property ((!trig_sel_one && !ext_irq_pin_one) [*3] |-> ext_req_flags[1])
        else $error("low level not flagged");
    a_level_drop: assert property ((!trig_sel_one && ext_irq_pin_one) [*3] |-> !ext_req_flags[1])
        else $error("flag not tracking pin");
    a_ex4_sticky: assert property (ext4_req_flag_x[0] && !ext4_flag_clear[0] |=> ext4_req_flag_x[0])
        else $error("source four flag lost");
    a_reti_blocks: assert property (core_in.is_reti [*3] |-> !$rose(call_out.req))
        else $error("call during return");
    a_ack_clears: assert property (call_out.req && core_in.call_ack && trig_sel_zero
        && call_out.vector == VEC_EX0 |-> ##[1:2] !ext_req_flags[0])
        else $error("edge flag kept after call");
    a_wake_on: assert property ((core_in.sleeping && global_enable && src_enable[SRC_EX1]
        && ext_req_flags[1]) [*2] |-> ##[0:1] wake)
        else $error("no wake");
    c_ex4_call: cover property (call_out.req && call_out.vector == VEC_EX4);
    c_wake: cover property ($rose(wake));
    c_ovl_call: cover property ($rose(call_out.req) && call_out.vector == VEC_OVL);
endmodule

bind eivu_top eivu_properties i_props (.clk_sys, .resetn, .ext_irq_pin_zero, .trig_sel_zero,
    .ext_irq_pin_one, .trig_sel_one,
    .ext4_flag_clear, .src_enable, .global_enable, .core_in, .call_out, .ext_req_flags,
    .ext4_req_flag_x, .wake);

/* verif/eivu_cpu_model.sv */
/* Core side model: instruction end, return, call entry, sleep.
   Assumes the testbench drives its controls at clock edges. */
`timescale 1ns/1ps
module eivu_cpu_model
    import eivu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire eivu_call_t call_out,
    input wire logic long_go,
    input wire logic reti_go,
    input wire logic sleep_req,
    output eivu_core_t core_in
);
    // ----
    // Core timing
    // ----
    logic [4:0] busy_q, busy_d;
    logic req_q;
    always_comb
    begin
        busy_d = (busy_q != 5'h0) ? busy_q - 5'h1 : 5'h0;
        if (long_go)
            busy_d = 5'(LONGEST_INSN_CYCLES - 1);
        core_in.last_cycle = (busy_q == 5'h0) && !long_go;
        core_in.is_reti = reti_go;
        core_in.reti_done = reti_go;
        core_in.call_ack = call_out.req && !req_q;
        core_in.sleeping = sleep_req;
    end
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            busy_q <= 5'h0;
        else
            busy_q <= busy_d;
        if (!resetn)
            req_q <= 1'b0;
        else
            req_q <= call_out.req;
    end
endmodule

/* verif/eivu_top_tb.sv */
/* Testbench for eivu_top with a core model.
   Assumes one machine cycle per clock. */
`timescale 1ns/1ps
module eivu_top_tb
    import eivu_pkg::*;
;
    logic clk_sys, resetn, ext_irq_pin_zero, ext_irq_pin_one, ext_irq_pin_two, ext_irq_pin_three;
    logic trig_sel_zero, trig_sel_one, global_enable, ext4_channel_enable, pwm_irq_global_enable;
    logic long_go, reti_go, sleep_req, wake;
    logic [7:0] ext4_pins, ext4_flag_clear, ext4_req_flag_x;
    logic [1:0] ext2_trig_field, ext3_trig_field, ext4_trig_field;
    logic [13:0] src_enable, periph_req;
    logic [2:0] pwm_channel_irq_enable, pwm_channel_irq_flag;
    logic [27:0] src_prio;
    logic [3:0] ext_req_flags;
    eivu_core_t core_in;
    eivu_call_t call_out;
    int err_total, compares, lat;
    int srcs[7] = '{2, 4, 5, 6, 7, 8, 13};
    eivu_top i_dut (.clk_sys, .resetn, .ext_irq_pin_zero, .ext_irq_pin_one, .ext_irq_pin_two,
        .ext_irq_pin_three, .ext4_pins, .trig_sel_zero, .trig_sel_one, .ext2_trig_field,
        .ext3_trig_field, .ext4_trig_field, .ext4_flag_clear, .src_enable, .global_enable,
        .ext4_channel_enable, .periph_req, .pwm_irq_global_enable, .pwm_channel_irq_enable,
        .pwm_channel_irq_flag, .src_prio, .core_in, .call_out, .ext_req_flags, .ext4_req_flag_x, .wake);
    eivu_cpu_model i_core (.clk_sys, .resetn, .call_out, .long_go, .reti_go, .sleep_req, .core_in);
    // ----
    // Tasks
    // ----
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic call(input logic [15:0] vec, output int n);
        int w;
        n = 0;
        w = 0;
        while (call_out.req !== 1'b1 && n < 60)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 60)
        begin
            err_total++;
            conclude();
        end
        chk("vector", vec, call_out.vector);
        while (call_out.req === 1'b1 && w < 20)
        begin
            @(posedge clk_sys);
            #1;
            w++;
        end
        chk("call width", 16'(CALL_CYCLES), 16'(w));
    endtask
    task automatic ret();
        @(posedge clk_sys);
        reti_go <= 1'b1;
        @(posedge clk_sys);
        reti_go <= 1'b0;
    endtask
    // ----
    // Sequence
    // ----
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial
    begin
        {ext_irq_pin_zero, ext_irq_pin_one, ext_irq_pin_two, ext_irq_pin_three, ext4_pins} = '1;
        {trig_sel_zero, trig_sel_one, long_go, reti_go, sleep_req, ext4_channel_enable} = '0;
        {ext4_flag_clear, ext2_trig_field, ext3_trig_field, ext4_trig_field, periph_req} = '0;
        {pwm_irq_global_enable, pwm_channel_irq_enable, pwm_channel_irq_flag, src_prio} = '0;
        src_enable = 14'h000a;
        global_enable = 1'b1;
        resetn = 1'b0;
        err_total = 0;
        compares = 0;
        repeat (16) @(posedge clk_sys);
        #1;
        chk("reset", 16'h0000, {call_out.vector[13:0], call_out.req, wake});
        chk("reset flags", 16'h0000, {4'h0, ext_req_flags, ext4_req_flag_x});
        @(posedge clk_sys);
        resetn <= 1'b1;
        trig_sel_zero <= 1'b1;
        @(posedge clk_sys);
        ext_irq_pin_zero <= 1'b0;
        #1;
        call(VEC_EX0, lat);
        chk("latency", 16'd4, 16'(lat));
        chk("flag zero", 16'h0000, 16'(ext_req_flags[0]));
        @(posedge clk_sys);
        ext_irq_pin_zero <= 1'b1;
        ret();
        $display("edge test done");
        @(posedge clk_sys);
        long_go <= 1'b1;
        ext_irq_pin_zero <= 1'b0;
        @(posedge clk_sys);
        long_go <= 1'b0;
        #1;
        call(VEC_EX0, lat);
        chk("long wait", 16'h0001, 16'(lat + 1 >= LONGEST_INSN_CYCLES));
        chk("bounds", 16'h0001, 16'(lat + 1 + CALL_CYCLES > 10 && lat + 1 + CALL_CYCLES < 37));
        @(posedge clk_sys);
        ext_irq_pin_zero <= 1'b1;
        reti_go <= 1'b1;
        @(posedge clk_sys);
        ext_irq_pin_zero <= 1'b0;
        repeat (12) @(posedge clk_sys);
        #1;
        chk("held off", 16'h0000, 16'(call_out.req));
        @(posedge clk_sys);
        reti_go <= 1'b0;
        #1;
        call(VEC_EX0, lat);
        @(posedge clk_sys);
        ext_irq_pin_zero <= 1'b1;
        ret();
        $display("latency tests done");
        @(posedge clk_sys);
        reti_go <= 1'b1;
        sleep_req <= 1'b1;
        ext_irq_pin_one <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        chk("wake", 16'h0001, 16'(wake));
        @(posedge clk_sys);
        reti_go <= 1'b0;
        sleep_req <= 1'b0;
        #1;
        call(VEC_EX1, lat);
        ret();
        #1;
        call(VEC_EX1, lat);
        @(posedge clk_sys);
        ext_irq_pin_one <= 1'b1;
        src_prio <= 28'h000_0004;
        ret();
        $display("level test done");
        @(posedge clk_sys);
        ext_irq_pin_zero <= 1'b0;
        #1;
        call(VEC_EX0, lat);
        chk("level", 16'h0001, 16'(call_out.level));
        @(posedge clk_sys);
        ext_irq_pin_zero <= 1'b1;
        ext_irq_pin_one <= 1'b0;
        repeat (15) @(posedge clk_sys);
        #1;
        chk("lower waits", 16'h0000, 16'(call_out.req));
        ret();
        #1;
        call(VEC_EX1, lat);
        @(posedge clk_sys);
        ext_irq_pin_one <= 1'b1;
        ext_irq_pin_zero <= 1'b0;
        #1;
        call(VEC_EX0, lat);
        ret();
        ret();
        $display("priority test done");
        @(posedge clk_sys);
        src_enable <= '1;
        src_prio <= '0;
        ext_irq_pin_zero <= 1'b1;
        foreach (srcs[k])
        begin
            @(posedge clk_sys);
            periph_req[srcs[k]] <= 1'b1;
            #1;
            call(VEC_TABLE[srcs[k]*16 +: 16], lat);
            @(posedge clk_sys);
            periph_req <= '0;
            ret();
        end
        @(posedge clk_sys);
        pwm_irq_global_enable <= 1'b1;
        pwm_channel_irq_enable <= 3'h4;
        pwm_channel_irq_flag <= 3'h4;
        #1;
        call(VEC_PWM, lat);
        @(posedge clk_sys);
        pwm_channel_irq_flag <= 3'h0;
        global_enable <= 1'b0;
        periph_req[0] <= 1'b1;
        ret();
        #1;
        call(VEC_OVL, lat);
        @(posedge clk_sys);
        periph_req <= '0;
        global_enable <= 1'b1;
        ret();
        $display("vector test done");
        for (int m = 0; m < 4; m++)
        begin
            @(posedge clk_sys);
            ext4_trig_field <= 2'(m);
            ext4_flag_clear <= '1;
            @(posedge clk_sys);
            ext4_flag_clear <= '0;
            @(posedge clk_sys);
            ext4_pins <= '0;
            repeat (3) @(posedge clk_sys);
            #1;
            chk("fall", (m != 2) ? 16'h00ff : 16'h0000, 16'(ext4_req_flag_x));
            @(posedge clk_sys);
            ext4_flag_clear <= '1;
            @(posedge clk_sys);
            ext4_flag_clear <= '0;
            ext4_pins <= '1;
            repeat (3) @(posedge clk_sys);
            #1;
            chk("rise", (m != 1) ? 16'h00ff : 16'h0000, 16'(ext4_req_flag_x));
        end
        repeat (12) @(posedge clk_sys);
        #1;
        chk("one enable", 16'h0000, 16'(call_out.req));
        @(posedge clk_sys);
        ext4_channel_enable <= 1'b1;
        #1;
        call(VEC_EX4, lat);
        chk("kept", 16'h00ff, 16'(ext4_req_flag_x));
        @(posedge clk_sys);
        ext4_flag_clear <= '1;
        ret();
        $display("source four test done");
        @(posedge clk_sys);
        ext2_trig_field <= TRIG_RISE;
        ext_irq_pin_two <= 1'b0;
        ext_irq_pin_three <= 1'b0;
        #1;
        call(VEC_EX3, lat);
        chk("flags two three", 16'h0008, 16'(ext_req_flags));
        @(posedge clk_sys);
        ext_irq_pin_two <= 1'b1;
        ext_irq_pin_three <= 1'b1;
        ret();
        #1;
        call(VEC_EX2, lat);
        chk("flags cleared", 16'h0000, 16'(ext_req_flags));
        ret();
        $display("sources two three test done");
        conclude();
    end
endmodule
